//--- verilog/hsc_params.svh
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH

// register indices, byte address is four times the index
`define HSC_IDX_W           10
`define HSC_IDX_TRACK_CNT   10'h14F
`define HSC_IDX_SW_CTRL     10'h150
`define HSC_IDX_EXIT_HI     10'h151
`define HSC_IDX_EXIT_LO     10'h152
`define HSC_IDX_STATUS      10'h1A0
`define HSC_IDX_MODE        10'h1A1

// reset values
`define HSC_RST_TRACK_CNT   8'h7F
`define HSC_RST_SW_CTRL     8'h00
`define HSC_RST_EXIT_HI     6'h02
`define HSC_RST_EXIT_LO     8'h00
`define HSC_RST_MODE        5'h00

// switch control bit positions
`define HSC_B_FORCE         6
`define HSC_B_EXIT_MODE     5
`define HSC_B_LOCK_LOSS     4
`define HSC_B_EXT_LOSS      3
`define HSC_B_TUNE_DET      2
`define HSC_B_PUMP_FLOAT    1
`define HSC_B_HOLD_EN       0

// own mode register fields
`define HSC_B_MANUAL        0
`define HSC_F_CHOICE        2:1
`define HSC_F_MULT          4:3

// tracking multiplier shifts: 4, 64, 1024, 16384
`define HSC_MULT_SH0        5'h02
`define HSC_MULT_SH1        5'h06
`define HSC_MULT_SH2        5'h0A
`define HSC_MULT_SH3        5'h0E

// switch interval
`define HSC_CLK_PERIOD_NS   40
`define HSC_SWITCH_TIME_NS  160
`define HSC_SWITCH_CYC      ((`HSC_SWITCH_TIME_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)

`endif

//--- verilog/hsc_pkg.sv
package hsc_pkg;
    typedef enum logic [1:0] {
        HSC_ST_LOCKED = 2'b00,
        HSC_ST_SWITCH = 2'b01,
        HSC_ST_HOLD   = 2'b10,
        HSC_ST_EXIT   = 2'b11
    } hsc_state_t;

    typedef enum logic [1:0] {
        HSC_IN_A = 2'b00,
        HSC_IN_B = 2'b01,
        HSC_IN_C = 2'b10
    } hsc_input_t;
endpackage : hsc_pkg

//--- verilog/hsc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hsc_cfg_if;
    logic [7:0]  track_cnt;
    logic [1:0]  track_mult;
    logic [7:0]  sw_ctrl;
    logic [13:0] exit_cnt;
    logic        manual_mode;
    logic [1:0]  manual_choice;
    logic        ctrl_wr;
    logic [7:0]  status;

    modport regs (
        output track_cnt,
        output track_mult,
        output sw_ctrl,
        output exit_cnt,
        output manual_mode,
        output manual_choice,
        output ctrl_wr,
        input  status
    );
    modport core (
        input  track_cnt,
        input  track_mult,
        input  sw_ctrl,
        input  exit_cnt,
        input  manual_mode,
        input  manual_choice,
        input  ctrl_wr,
        output status
    );
endinterface : hsc_cfg_if
`default_nettype wire

//--- verilog/hsc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsc_params.svh"
module hsc_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [11:0] adr,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel,
    output logic      [31:0] dat_o,
    output logic             ack,
    hsc_cfg_if.regs          cfg
);
    import hsc_pkg::*;

    logic [7:0]  track_ff, nxt_track;
    logic [7:0]  ctrl_ff, nxt_ctrl;
    logic [5:0]  hi_ff, nxt_hi;
    logic [7:0]  lo_ff, nxt_lo;
    logic [4:0]  mode_ff, nxt_mode;
    logic        ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic        wr_ff, nxt_wr;
    logic [`HSC_IDX_W-1:0] idx;
    logic        take;
    logic        wr;

    assign idx = adr[11:2];

    always_comb begin
        take      = cyc & stb & ~ack_ff;
        wr        = take & we & sel[0];
        nxt_ack   = take;
        nxt_track = track_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_hi    = hi_ff;
        nxt_lo    = lo_ff;
        nxt_mode  = mode_ff;
        nxt_wr    = 1'b0;
        nxt_dat   = 32'h0000_0000;
        if (wr) begin
            unique case (idx)
                `HSC_IDX_TRACK_CNT: nxt_track = dat_i[7:0];
                `HSC_IDX_SW_CTRL: begin
                    nxt_ctrl = {1'b0, dat_i[6:0]};
                    nxt_wr   = 1'b1;
                end
                `HSC_IDX_EXIT_HI:   nxt_hi   = dat_i[5:0];
                `HSC_IDX_EXIT_LO:   nxt_lo   = dat_i[7:0];
                `HSC_IDX_MODE:      nxt_mode = dat_i[4:0];
                default:            nxt_wr   = 1'b0;
            endcase
        end
        if (take && !we) begin
            unique case (idx)
                `HSC_IDX_TRACK_CNT: nxt_dat = {24'h00_0000, track_ff};
                `HSC_IDX_SW_CTRL:   nxt_dat = {24'h00_0000, ctrl_ff};
                `HSC_IDX_EXIT_HI:   nxt_dat = {26'h000_0000, hi_ff};
                `HSC_IDX_EXIT_LO:   nxt_dat = {24'h00_0000, lo_ff};
                `HSC_IDX_STATUS:    nxt_dat = {24'h00_0000, cfg.status};
                `HSC_IDX_MODE:      nxt_dat = {27'h000_0000, mode_ff};
                default:            nxt_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            track_ff <= `HSC_RST_TRACK_CNT;
            ctrl_ff  <= `HSC_RST_SW_CTRL;
            hi_ff    <= `HSC_RST_EXIT_HI;
            lo_ff    <= `HSC_RST_EXIT_LO;
            mode_ff  <= `HSC_RST_MODE;
            ack_ff   <= 1'b0;
            dat_ff   <= 32'h0000_0000;
            wr_ff    <= 1'b0;
        end else if (ce) begin
            track_ff <= nxt_track;
            ctrl_ff  <= nxt_ctrl;
            hi_ff    <= nxt_hi;
            lo_ff    <= nxt_lo;
            mode_ff  <= nxt_mode;
            ack_ff   <= nxt_ack;
            dat_ff   <= nxt_dat;
            wr_ff    <= nxt_wr;
        end
    end

    assign ack               = ack_ff;
    assign dat_o             = dat_ff;
    assign cfg.track_cnt     = track_ff;
    assign cfg.track_mult    = mode_ff[`HSC_F_MULT];
    assign cfg.sw_ctrl       = ctrl_ff;
    assign cfg.exit_cnt      = {hi_ff, lo_ff};
    assign cfg.manual_mode   = mode_ff[`HSC_B_MANUAL];
    assign cfg.manual_choice = mode_ff[`HSC_F_CHOICE];
    assign cfg.ctrl_wr       = wr_ff;
endmodule : hsc_regs
`default_nettype wire

//--- verilog/hsc_top.sv
// Behaviour
// - in tracked mode, DAC update period is multiplier times 8-bit tracking count.
// - multiplier codes 0..3 give 4, 64, 1024, 16384.
// - manual mode with force bit 6 locks only onto the manual input choice.
// - force bit set disables dynamic digital delay.
// - exit mode bit 5 clear: begin holdover exit when loss status shows input active.
// - exit mode bit 5 set: begin holdover exit on digital lock flag.
// - bit 4 set: lock flag falling edge is a switch event; clear: none.
// - bit 3 set: loss status comes from the three pins, not internal detectors.
// - bit 2 set and tune trip: mark current input invalid; raise switch event only in the locked state.
// - bit 1 set: charge pump floats while an input switch lasts.
// - holdover is entered only while bit 0 is set.
// - exit holdover after valid compare clocks reach the 14-bit exit lock count.
// - tune detection enters holdover when tune voltage reaches the low or the high trip level.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_params.svh"
module hsc_top (
    input  wire logic                MCLK,
    input  wire logic                RESETN,
    input  wire logic                CE,
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [11:0]         WB_ADR_I,
    input  wire logic [31:0]         WB_DAT_I,
    input  wire logic [3:0]          WB_SEL_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    input  wire logic                DIGITAL_LOCK_FLAG,
    input  wire logic                COMPARE_CLK_VALID,
    input  wire logic [2:0]          INT_SIGNAL_LOSS,
    input  wire logic                SELECT_PIN_ZERO,
    input  wire logic                SELECT_PIN_ONE,
    input  wire logic                STATUS_PIN_ONE,
    input  wire logic                TUNE_LOW_TRIP,
    input  wire logic                TUNE_HIGH_TRIP,
    output hsc_pkg::hsc_input_t      REF_SELECT,
    output logic                     HOLDOVER_ACTIVE,
    output logic                     PUMP_FLOAT,
    output logic                     DYN_DELAY_OFF,
    output logic                     SWITCH_EVENT,
    output logic                     DAC_TRACK_TICK
);
    import hsc_pkg::*;

    hsc_cfg_if cfg ();

    hsc_regs u_regs (
        .clk   (MCLK),
        .rst_n (RESETN),
        .ce    (CE),
        .cyc   (WB_CYC_I),
        .stb   (WB_STB_I),
        .we    (WB_WE_I),
        .adr   (WB_ADR_I),
        .dat_i (WB_DAT_I),
        .sel   (WB_SEL_I),
        .dat_o (WB_DAT_O),
        .ack   (WB_ACK_O),
        .cfg   (cfg)
    );

    // pin synchronisers
    logic [4:0] meta_ff, nxt_meta;
    logic [4:0] pin_ff, nxt_pin;

    always_comb begin
        nxt_meta = {TUNE_HIGH_TRIP, TUNE_LOW_TRIP, STATUS_PIN_ONE, SELECT_PIN_ONE,
                    SELECT_PIN_ZERO};
        nxt_pin  = meta_ff;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_ff <= 5'h00;
            pin_ff  <= 5'h00;
        end else if (CE) begin
            meta_ff <= nxt_meta;
            pin_ff  <= nxt_pin;
        end
    end

    // control state
    hsc_state_t  state_ff, nxt_state;
    hsc_input_t  sel_ff, nxt_sel;
    logic [2:0]  invalid_ff, nxt_invalid;
    logic        lock_d_ff, nxt_lock_d;
    logic [2:0]  sw_cnt_ff, nxt_sw_cnt;
    logic [13:0] exit_ff, nxt_exit;
    logic [21:0] track_ff, nxt_track;
    logic        hold_ff, nxt_hold;
    logic        float_ff, nxt_float;
    logic        ddly_ff, nxt_ddly;
    logic        event_ff, nxt_event;
    logic        tick_ff, nxt_tick;
    logic [7:0]  status_ff, nxt_status;

    logic [2:0]  loss_src;
    logic [2:0]  valid;
    logic        forced;
    logic        cur_valid;
    logic        lock_ev;
    logic        tune_ev;
    logic        exit_ok;
    logic        cand_ok;
    hsc_input_t  cand;
    hsc_input_t  cand1;
    hsc_input_t  cand2;
    logic [4:0]  shift;
    logic [21:0] period;

    always_comb begin
        // loss source selection
        loss_src  = cfg.sw_ctrl[`HSC_B_EXT_LOSS] ? pin_ff[2:0] : INT_SIGNAL_LOSS;
        valid     = ~loss_src & ~invalid_ff;
        forced    = cfg.manual_mode & cfg.sw_ctrl[`HSC_B_FORCE];
        cur_valid = valid[sel_ff];
        lock_ev   = cfg.sw_ctrl[`HSC_B_LOCK_LOSS] & lock_d_ff & ~DIGITAL_LOCK_FLAG;
        tune_ev   = cfg.sw_ctrl[`HSC_B_TUNE_DET] & (pin_ff[3] | pin_ff[4]);
        exit_ok   = cfg.sw_ctrl[`HSC_B_EXIT_MODE] ? DIGITAL_LOCK_FLAG : cur_valid;

        // next input in rotation
        unique case (sel_ff)
            HSC_IN_A: begin
                cand1 = HSC_IN_B;
                cand2 = HSC_IN_C;
            end
            HSC_IN_B: begin
                cand1 = HSC_IN_C;
                cand2 = HSC_IN_A;
            end
            default: begin
                cand1 = HSC_IN_A;
                cand2 = HSC_IN_B;
            end
        endcase
        if (forced) begin
            cand    = hsc_input_t'(cfg.manual_choice);
            cand_ok = 1'b1;
        end else if (valid[cand1]) begin
            cand    = cand1;
            cand_ok = 1'b1;
        end else begin
            cand    = cand2;
            cand_ok = valid[cand2];
        end

        // tracking period
        unique case (cfg.track_mult)
            2'h0: shift = `HSC_MULT_SH0;
            2'h1: shift = `HSC_MULT_SH1;
            2'h2: shift = `HSC_MULT_SH2;
            2'h3: shift = `HSC_MULT_SH3;
        endcase
        period = {14'h0000, cfg.track_cnt} << shift;
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_sel     = sel_ff;
        nxt_invalid = cfg.ctrl_wr ? 3'h0 : invalid_ff;
        nxt_lock_d  = DIGITAL_LOCK_FLAG;
        nxt_sw_cnt  = sw_cnt_ff;
        nxt_exit    = exit_ff;
        nxt_track   = 22'h00_0000;
        nxt_event   = 1'b0;
        nxt_tick    = 1'b0;
        unique case (state_ff)
            HSC_ST_LOCKED: begin
                if (lock_ev || tune_ev || !cur_valid) begin
                    nxt_event = 1'b1;
                    if (tune_ev) begin
                        nxt_invalid[sel_ff] = 1'b1;
                    end
                    if (cfg.sw_ctrl[`HSC_B_HOLD_EN]) begin
                        nxt_state = HSC_ST_HOLD;
                    end else if (cand_ok) begin
                        nxt_state  = HSC_ST_SWITCH;
                        nxt_sel    = cand;
                        nxt_sw_cnt = 3'(`HSC_SWITCH_CYC);
                    end
                end else if (forced && sel_ff != cand) begin
                    nxt_state  = HSC_ST_SWITCH;
                    nxt_sel    = cand;
                    nxt_sw_cnt = 3'(`HSC_SWITCH_CYC);
                end else if (period != 22'h00_0000) begin
                    nxt_track = track_ff + 22'h00_0001;
                    if (nxt_track >= period) begin
                        nxt_track = 22'h00_0000;
                        nxt_tick  = 1'b1;
                    end
                end
            end
            HSC_ST_SWITCH: begin
                nxt_sw_cnt = sw_cnt_ff - 3'h1;
                if (sw_cnt_ff <= 3'h1) begin
                    nxt_state = HSC_ST_LOCKED;
                end
            end
            HSC_ST_HOLD: begin
                nxt_exit = 14'h0000;
                if (!cfg.sw_ctrl[`HSC_B_HOLD_EN]) begin
                    nxt_state = HSC_ST_LOCKED;
                end else if (!cur_valid && !forced && cand_ok) begin
                    nxt_sel = cand;
                end else if (exit_ok) begin
                    nxt_state = HSC_ST_EXIT;
                end
            end
            HSC_ST_EXIT: begin
                if (!exit_ok) begin
                    nxt_state = HSC_ST_HOLD;
                    nxt_exit  = 14'h0000;
                end else if (exit_ff >= cfg.exit_cnt) begin
                    nxt_state = HSC_ST_LOCKED;
                end else if (COMPARE_CLK_VALID) begin
                    nxt_exit = exit_ff + 14'h0001;
                end
            end
        endcase
        if (tune_ev && state_ff != HSC_ST_LOCKED) begin
            nxt_invalid[sel_ff] = 1'b1;
        end
        nxt_hold   = (nxt_state == HSC_ST_HOLD) || (nxt_state == HSC_ST_EXIT);
        nxt_float  = (nxt_state == HSC_ST_SWITCH) & cfg.sw_ctrl[`HSC_B_PUMP_FLOAT];
        nxt_ddly   = cfg.sw_ctrl[`HSC_B_FORCE];
        nxt_status = {nxt_invalid, nxt_state == HSC_ST_SWITCH, nxt_state == HSC_ST_EXIT,
                      nxt_hold, nxt_sel};
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff   <= HSC_ST_LOCKED;
            sel_ff     <= HSC_IN_A;
            invalid_ff <= 3'h0;
            lock_d_ff  <= 1'b0;
            sw_cnt_ff  <= 3'h0;
            exit_ff    <= 14'h0000;
            track_ff   <= 22'h00_0000;
            hold_ff    <= 1'b0;
            float_ff   <= 1'b0;
            ddly_ff    <= 1'b0;
            event_ff   <= 1'b0;
            tick_ff    <= 1'b0;
            status_ff  <= 8'h00;
        end else if (CE) begin
            state_ff   <= nxt_state;
            sel_ff     <= nxt_sel;
            invalid_ff <= nxt_invalid;
            lock_d_ff  <= nxt_lock_d;
            sw_cnt_ff  <= nxt_sw_cnt;
            exit_ff    <= nxt_exit;
            track_ff   <= nxt_track;
            hold_ff    <= nxt_hold;
            float_ff   <= nxt_float;
            ddly_ff    <= nxt_ddly;
            event_ff   <= nxt_event;
            tick_ff    <= nxt_tick;
            status_ff  <= nxt_status;
        end
    end

    assign cfg.status      = status_ff;
    assign REF_SELECT      = sel_ff;
    assign HOLDOVER_ACTIVE = hold_ff;
    assign PUMP_FLOAT      = float_ff;
    assign DYN_DELAY_OFF   = ddly_ff;
    assign SWITCH_EVENT    = event_ff;
    assign DAC_TRACK_TICK  = tick_ff;
endmodule : hsc_top
`default_nettype wire

//--- sim/hsc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_partner #(
    parameter int DIV = 3
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       lock_c,
    input  wire logic       pd_run,
    input  wire logic [2:0] lost_c,
    input  wire logic [2:0] pin_c,
    output logic            lock_ff,
    output logic            pd_ff,
    output logic      [2:0] loss_ff,
    output logic      [2:0] pin_ff
);
    int cnt_ff;
    // compare clocks come only from a locked loop, one every DIV cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 0;
            lock_ff <= 1'b1;
            pd_ff   <= 1'b0;
            loss_ff <= 3'h0;
            pin_ff  <= 3'h0;
        end else begin
            lock_ff <= lock_c;
            loss_ff <= lost_c;
            pin_ff  <= pin_c;
            pd_ff   <= pd_run && lock_ff && cnt_ff == DIV - 1;
            if (pd_run) begin
                cnt_ff <= (cnt_ff == DIV - 1) ? 0 : cnt_ff + 1;
            end
        end
    end
endmodule : hsc_partner
`default_nettype wire

//--- sim/hsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_checker (
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        CE,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        HOLDOVER_ACTIVE,
    input wire logic        PUMP_FLOAT,
    input wire logic        DYN_DELAY_OFF,
    input wire logic        SWITCH_EVENT,
    input wire logic        DAC_TRACK_TICK
);
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    // shadow of the switch control register, taken from bus writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (CE && WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
            && WB_ADR_I[11:2] == 10'h150) begin
            nxt_ctrl = WB_DAT_I[7:0];
        end
    end
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    rdata_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    rdata_resv_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    tick_gap_a: assert property (DAC_TRACK_TICK |=> !DAC_TRACK_TICK [*3])
        else $error("tracking ticks closer than four cycles");
    tick_event_a: assert property (SWITCH_EVENT |-> !DAC_TRACK_TICK)
        else $error("tracking tick during switch event");
    float_en_a: assert property (PUMP_FLOAT |-> ctrl_ff[1])
        else $error("pump floats while disabled");
    float_len_a: assert property ($rose(PUMP_FLOAT) |-> PUMP_FLOAT [*4] ##1 !PUMP_FLOAT)
        else $error("pump float not four cycles");
    hold_en_a: assert property ($rose(HOLDOVER_ACTIVE) |-> $past(ctrl_ff[0]))
        else $error("holdover entered while disabled");
    delay_off_a: assert property (DYN_DELAY_OFF == $past(ctrl_ff[6]))
        else $error("dynamic delay disable wrong");
    hold_in_c: cover property ($rose(HOLDOVER_ACTIVE));
    hold_out_c: cover property ($fell(HOLDOVER_ACTIVE));
    float_c: cover property ($rose(PUMP_FLOAT));
endmodule : hsc_checker
bind hsc_top hsc_checker u_chk (
    .MCLK, .RESETN, .CE, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I,
    .WB_SEL_I, .WB_DAT_O, .WB_ACK_O, .HOLDOVER_ACTIVE, .PUMP_FLOAT, .DYN_DELAY_OFF,
    .SWITCH_EVENT, .DAC_TRACK_TICK
);
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hsc_pkg::*;
    logic        mclk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'hF, bsel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    logic        lock_c = 1'b1, pd_run = 1'b0, trip_lo = 1'b0, trip_hi = 1'b0;
    logic [2:0]  lost_c = 3'h0, pin_c = 3'h0, int_loss, pins;
    logic        ack, lock, pd, hold, pf, ddo, sev, tick;
    hsc_input_t  ref_sel;
    int          error_cnt = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    hsc_partner #(.DIV(3)) u_far (.clk(mclk), .rst_n(resetn), .lock_c(lock_c),
        .pd_run(pd_run), .lost_c(lost_c), .pin_c(pin_c), .lock_ff(lock), .pd_ff(pd),
        .loss_ff(int_loss), .pin_ff(pins));
    hsc_top DUT (.MCLK(mclk), .RESETN(resetn), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .DIGITAL_LOCK_FLAG(lock), .COMPARE_CLK_VALID(pd),
        .INT_SIGNAL_LOSS(int_loss), .SELECT_PIN_ZERO(pins[0]), .SELECT_PIN_ONE(pins[1]),
        .STATUS_PIN_ONE(pins[2]), .TUNE_LOW_TRIP(trip_lo), .TUNE_HIGH_TRIP(trip_hi),
        .REF_SELECT(ref_sel), .HOLDOVER_ACTIVE(hold), .PUMP_FLOAT(pf),
        .DYN_DELAY_OFF(ddo), .SWITCH_EVENT(sev), .DAC_TRACK_TICK(tick));
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= bsel;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n == 50) chk(32'h1, 32'h0);
    endtask : wb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    task automatic watch(input int n, output int ev, output int fl);
        ev = 0;
        fl = 0;
        repeat (n) begin
            @(posedge mclk);
            ev += int'(sev === 1'b1);
            fl += int'(pf === 1'b1);
        end
    endtask : watch
    task automatic pulses(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        pd_run <= 1'b1;
        while (k < n && t < 200) begin
            @(posedge mclk);
            t++;
            k += int'(pd === 1'b1);
        end
        pd_run <= 1'b0;
    endtask : pulses
    task automatic gap(output int g);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (tick !== 1'b1 && n < 40000);
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (tick !== 1'b1 && g < 40000);
    endtask : gap
    task automatic t_track;
        int g;
        rd_chk(12'h53C, 8'h7F);
        rd_chk(12'h684, 8'h00);
        for (int m = 0; m < 4; m++) begin
            if (m > 0) wr(12'h684, 8'(m << 3));
            wr(12'h53C, (m == 0) ? 8'h03 : 8'h01);
            gap(g);
            chk(g, (m == 0) ? 32'd12 : 32'd1 << (2 + 4 * m));
        end
    endtask : t_track
    task automatic t_regs;
        rd_chk(12'h540, 8'h00);
        rd_chk(12'h544, 8'h02);
        rd_chk(12'h548, 8'h00);
        wr(12'h544, 8'hFF);
        rd_chk(12'h544, 8'h3F);
        wr(12'h540, 8'h80);
        rd_chk(12'h540, 8'h00);
        wr(12'h7FC, 8'h5A);
        rd_chk(12'h7FC, 8'h00);
        wr(12'h53C, 8'hFF);
        rd_chk(12'h53C, 8'hFF);
        bsel = 4'hE;
        wr(12'h53C, 8'h11);
        bsel = 4'hF;
        rd_chk(12'h53C, 8'hFF);
    endtask : t_regs
    task automatic t_lock;
        int ev;
        int fl;
        wr(12'h540, 8'h12);
        lock_c <= 1'b0;
        watch(12, ev, fl);
        chk(ev, 1);
        chk(fl, 4);
        chk(ref_sel, HSC_IN_B);
        lock_c <= 1'b1;
        wr(12'h540, 8'h02);
        lock_c <= 1'b0;
        watch(12, ev, fl);
        chk(ev, 0);
        lock_c <= 1'b1;
    endtask : t_lock
    task automatic t_ext;
        pin_c <= 3'b010;
        idle(8);
        chk(ref_sel, HSC_IN_B);
        wr(12'h540, 8'h08);
        idle(8);
        chk(ref_sel, HSC_IN_C);
        pin_c <= 3'b000;
        wr(12'h540, 8'h00);
    endtask : t_ext
    task automatic t_force;
        for (int c = 1; c >= 0; c--) begin
            wr(12'h684, 8'((c << 1) | 1));
            wr(12'h540, 8'h40);
            idle(8);
            chk(ref_sel, 32'(c));
            chk(ddo, 1'b1);
        end
        wr(12'h684, 8'h00);
        wr(12'h540, 8'h00);
        idle(2);
        chk(ddo, 1'b0);
    endtask : t_force
    task automatic t_hold;
        wr(12'h544, 8'h00);
        wr(12'h548, 8'h03);
        lost_c <= 3'h7;
        idle(6);
        chk(hold, 1'b0);
        wr(12'h540, 8'h01);
        idle(6);
        chk(hold, 1'b1);
        lost_c <= 3'h0;
        idle(4);
        pulses(2);
        lost_c <= 3'h7;
        idle(4);
        lost_c <= 3'h0;
        idle(4);
        pulses(2);
        idle(4);
        chk(hold, 1'b1);
        pulses(1);
        idle(6);
        chk(hold, 1'b0);
        wr(12'h540, 8'h21);
        lock_c <= 1'b0;
        lost_c <= 3'h7;
        idle(6);
        lost_c <= 3'h0;
        idle(8);
        chk(hold, 1'b1);
        lock_c <= 1'b1;
        idle(4);
        pulses(3);
        idle(6);
        chk(hold, 1'b0);
        wr(12'h540, 8'h00);
    endtask : t_hold
    task automatic t_tune;
        logic [7:0] q;
        logic [1:0] s;
        s = ref_sel;
        wr(12'h540, 8'h04);
        trip_hi <= 1'b1;
        idle(3);
        trip_hi <= 1'b0;
        idle(12);
        chk(ref_sel !== s, 1'b1);
        wb(1'b0, 12'h680, 8'h00, q);
        chk(q[5 + s], 1'b1);
        wr(12'h540, 8'h05);
        trip_lo <= 1'b1;
        idle(3);
        trip_lo <= 1'b0;
        idle(4);
        chk(hold, 1'b1);
        wr(12'h540, 8'h00);
    endtask : t_tune
    initial begin
        #(60000 * 40);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_track();
        t_regs();
        t_lock();
        t_ext();
        t_force();
        t_hold();
        t_tune();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
